//--- hw/logic_supply_monitor.sv
`timescale 1ns/100ps
// Operation
// - Disable bridge after under-voltage holds for the first filter time.
// - Pull fault pin low after under-voltage holds for the long filter time.
// - End under-voltage only after first filter time; keep configuration.
// - Release pin after under-voltage only once minimum hold time passed.
// - Latched under-voltage flag sits at bit 1 of frame 8a.
// - Live under-voltage flag sits at bit 0 of frame 12b.
// - Hold bridge disabled while filtered over-voltage is present.
// - Pull fault pin low when over-voltage filter expires.
// - Release pin after over-voltage when removal filtered and hold expired.
// - Keep bridge disabled until filtered over-voltage removal.
// - Over-voltage latched at bit 2 of 8a, live at bit 1 of 12b.
// - Forward filtered over-voltage to global failure logic.
// - Start duration counter when filtered over-voltage begins.
// - Duration counter stops at maximum or when over-voltage ends.
// - Duration is 3-bit latched code; 000 unused, 001 no event default.
// - Codes 010 to 111 cover ranges up to and beyond 1000 ms.
// - Duration code sits at bits 11 to 9 of frame 12a.
// - New event replaces code unless shorter than range already held.
// - Reading code clears it; persisting event restarts the counter.
// - Reset returns all settings and status to defaults.
// - Reset asserts and is released in step with the clock.
module logic_supply_monitor
    import supply_mon_pkg::*;
#(
    parameter int unsigned FILT_LIMIT = FILT_CYCLES,
    parameter int unsigned LOW_PIN_LIMIT = LOW_PIN_CYCLES,
    parameter int unsigned HOLD_LIMIT = HOLD_CYCLES,
    parameter int unsigned MS_LIMIT = MS_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic low_cmp,
    input wire logic high_cmp,
    input wire logic code_read,
    input wire logic diag_clear,
    output logic bridge_disable,
    output logic fault_pin_level,
    output logic fault_pin_oe,
    output logic high_to_global_fail,
    output logic [FRAME_W-1:0] frame_8a,
    output logic [FRAME_W-1:0] frame_12a,
    output logic [FRAME_W-1:0] frame_12b
);
    // ==========================================================
    // Comparator synchronisers
    // ==========================================================
    logic [1:0] cmp_meta_ff;
    logic [1:0] cmp_sync_ff;

    // Comparators are asynchronous; the first stage feeds only the second.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmp_meta_ff <= 2'h0;
            cmp_sync_ff <= 2'h0;
        end else begin
            cmp_meta_ff <= {high_cmp, low_cmp};
            cmp_sync_ff <= cmp_meta_ff;
        end
    end

    // ==========================================================
    // Filters
    // ==========================================================
    filter_if low_f ();
    filter_if high_f ();
    logic low_filt;
    logic high_filt;

    assign low_f.raw = cmp_sync_ff[0];
    assign high_f.raw = cmp_sync_ff[1];
    assign low_filt = low_f.filt;
    assign high_filt = high_f.filt;

    level_filter #(.LIMIT(FILT_LIMIT)) u_low_filter (
        .clk(clk),
        .rst_n(rst_n),
        .port(low_f.filter)
    );

    level_filter #(.LIMIT(FILT_LIMIT)) u_high_filter (
        .clk(clk),
        .rst_n(rst_n),
        .port(high_f.filter)
    );

    // ==========================================================
    // Long under-voltage timer for the fault pin
    // ==========================================================
    logic [31:0] low_long_cnt_ff;
    logic low_long_ff;

    // Counts only while the raw under-voltage stays asserted without a break.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            low_long_cnt_ff <= 32'h0;
        end else if (!cmp_sync_ff[0] || low_long_ff) begin
            low_long_cnt_ff <= 32'h0;
        end else begin
            low_long_cnt_ff <= low_long_cnt_ff + 32'h1;
        end
    end

    // The pin request ends only when the filtered condition is removed.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            low_long_ff <= 1'b0;
        end else if (!low_long_ff &&
                     low_long_cnt_ff == 32'(LOW_PIN_LIMIT - 1)) begin
            low_long_ff <= 1'b1;
        end else if (!low_filt && !cmp_sync_ff[0]) begin
            low_long_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Fault pin with minimum hold
    // ==========================================================
    logic pin_fault;
    logic [31:0] hold_cnt_ff;
    logic hold_done;
    logic pin_oe_ff;

    assign pin_fault = low_long_ff | high_filt;
    assign hold_done = hold_cnt_ff == 32'(HOLD_LIMIT - 1);

    // Hold time is measured from the moment the pin went low.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_cnt_ff <= 32'h0;
        end else if (!pin_oe_ff) begin
            hold_cnt_ff <= 32'h0;
        end else if (!hold_done) begin
            hold_cnt_ff <= hold_cnt_ff + 32'h1;
        end
    end

    // Release needs both the fault gone and the hold expired.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_oe_ff <= 1'b0;
        end else if (pin_fault) begin
            pin_oe_ff <= 1'b1;
        end else if (hold_done) begin
            pin_oe_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Bridge disable and global failure feed
    // ==========================================================
    logic bridge_dis_ff;
    logic fail_ff;
    logic pin_o_ff;

    // Disable follows the filtered levels, so removal is filtered too.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bridge_dis_ff <= 1'b1;
            fail_ff <= 1'b0;
            pin_o_ff <= 1'b0;
        end else begin
            bridge_dis_ff <= low_filt | high_filt;
            fail_ff <= high_filt;
            pin_o_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Latched flags
    // ==========================================================
    logic low_latched_ff;
    logic high_latched_ff;

    // A live condition in the clear cycle keeps the flag set.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            low_latched_ff <= 1'b0;
            high_latched_ff <= 1'b0;
        end else begin
            low_latched_ff <= low_filt | (low_latched_ff & ~diag_clear);
            high_latched_ff <= high_filt | (high_latched_ff & ~diag_clear);
        end
    end

    // ==========================================================
    // Over-voltage duration measurement
    // ==========================================================
    logic high_filt_d_ff;
    logic high_start;
    logic [31:0] tick_cnt_ff;
    logic [9:0] ms_cnt_ff;
    logic running;
    logic [2:0] cur_code;
    logic [2:0] code_ff;

    assign high_start = (high_filt & ~high_filt_d_ff) |
                        (high_filt & code_read);
    assign running = high_filt && ms_cnt_ff < DUR_MS_1000;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            high_filt_d_ff <= 1'b0;
        end else begin
            high_filt_d_ff <= high_filt;
        end
    end

    // Millisecond prescaler and counter; saturating at the top range
    // keeps the counter narrow.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tick_cnt_ff <= 32'h0;
            ms_cnt_ff <= 10'h0;
        end else if (high_start) begin
            tick_cnt_ff <= 32'h0;
            ms_cnt_ff <= 10'h0;
        end else if (running) begin
            if (tick_cnt_ff == 32'(MS_LIMIT - 1)) begin
                tick_cnt_ff <= 32'h0;
                ms_cnt_ff <= ms_cnt_ff + 10'h1;
            end else begin
                tick_cnt_ff <= tick_cnt_ff + 32'h1;
            end
        end
    end

    // Range lookup of the elapsed time.
    always_comb begin
        if (ms_cnt_ff < DUR_MS_10) begin
            cur_code = CODE_TO_10;
        end else if (ms_cnt_ff < DUR_MS_30) begin
            cur_code = CODE_TO_30;
        end else if (ms_cnt_ff < DUR_MS_100) begin
            cur_code = CODE_TO_100;
        end else if (ms_cnt_ff < DUR_MS_300) begin
            cur_code = CODE_TO_300;
        end else if (ms_cnt_ff < DUR_MS_1000) begin
            cur_code = CODE_TO_1000;
        end else begin
            cur_code = CODE_OVER_1000;
        end
    end

    // A read clears to no-event; a live event restarts at the first range.
    // The start cycle is skipped so a stale count cannot raise the code.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            code_ff <= CODE_NONE;
        end else if (code_read) begin
            code_ff <= high_filt ? CODE_TO_10 : CODE_NONE;
        end else if (high_filt && !high_start && cur_code > code_ff) begin
            code_ff <= cur_code;
        end
    end

    // ==========================================================
    // Answer frame fields
    // ==========================================================
    logic [FRAME_W-1:0] f8a_ff;
    logic [FRAME_W-1:0] f12a_ff;
    logic [FRAME_W-1:0] f12b_ff;

    // Frames are re-registered each cycle; unused bits read as zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            f8a_ff <= '0;
            f12a_ff <= '0;
            f12b_ff <= '0;
        end else begin
            f8a_ff <= '0;
            f12a_ff <= '0;
            f12b_ff <= '0;
            f8a_ff[F8A_LOW_LATCHED] <= low_latched_ff;
            f8a_ff[F8A_HIGH_LATCHED] <= high_latched_ff;
            f12b_ff[F12B_LOW_LIVE] <= low_filt;
            f12b_ff[F12B_HIGH_LIVE] <= high_filt;
            f12a_ff[F12A_CODE_MSB:F12A_CODE_LSB] <= code_ff;
        end
    end

    assign bridge_disable = bridge_dis_ff;
    assign fault_pin_level = pin_o_ff;
    assign fault_pin_oe = pin_oe_ff;
    assign high_to_global_fail = fail_ff;
    assign frame_8a = f8a_ff;
    assign frame_12a = f12a_ff;
    assign frame_12b = f12b_ff;

    // ==========================================================
    // Assertions
    // ==========================================================
    AST_PIN_LONG_LOW: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(low_long_ff) |->
        $past(low_long_cnt_ff) == 32'(LOW_PIN_LIMIT - 1))
        else $error("long under-voltage set at wrong count");
    AST_PIN_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(pin_oe_ff) |-> $past(hold_done))
        else $error("fault pin released before hold time");
    AST_PIN_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        high_filt |=> pin_oe_ff)
        else $error("fault pin not driven during over-voltage");
    AST_PIN_REL: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(pin_oe_ff) |-> !$past(high_filt) && !$past(low_long_ff))
        else $error("fault pin released with fault present");
    AST_BRIDGE: assert property (@(posedge clk) disable iff (!rst_n)
        (low_filt || high_filt) |=> bridge_dis_ff)
        else $error("bridge not disabled during supply fault");
    AST_BRIDGE_FREE: assert property (@(posedge clk) disable iff (!rst_n)
        !low_filt && !high_filt ##1 !low_filt && !high_filt
        |-> !bridge_dis_ff)
        else $error("bridge held disabled without fault");
    AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        low_latched_ff && !diag_clear |=> low_latched_ff)
        else $error("latched flag lost without clear");
    AST_LIVE_FRAME: assert property (@(posedge clk) disable iff (!rst_n)
        high_filt |=> f12b_ff[F12B_HIGH_LIVE]
        ##1 f8a_ff[F8A_HIGH_LATCHED])
        else $error("over-voltage flags missing in frames");
    AST_CODE_USED: assert property (@(posedge clk) disable iff (!rst_n)
        code_ff != CODE_UNUSED)
        else $error("duration code holds unused value");
    AST_CODE_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
        !code_read |=> code_ff >= $past(code_ff))
        else $error("duration code shrank without read");
    AST_READ_CLR: assert property (@(posedge clk) disable iff (!rst_n)
        code_read && !high_filt |=> code_ff == CODE_NONE)
        else $error("duration code not cleared on read");
    AST_FAIL: assert property (@(posedge clk) disable iff (!rst_n)
        high_filt |=> fail_ff)
        else $error("over-voltage not forwarded to failure logic");

    COV_LONG_LOW: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(low_long_ff));
    COV_CODE_30: cover property (@(posedge clk) disable iff (!rst_n)
        code_ff == CODE_TO_30);
    COV_RELEASE: cover property (@(posedge clk) disable iff (!rst_n)
        $fell(pin_oe_ff));
    COV_READ_LIVE: cover property (@(posedge clk) disable iff (!rst_n)
        code_read && high_filt);
endmodule

//--- hw/supply_mon_pkg.sv
package supply_mon_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned FILT_TIME_US = 2000;
    localparam int unsigned LOW_PIN_TIME_US = 415000;
    localparam int unsigned HOLD_TIME_US = 2000;
    localparam int unsigned MS_TIME_US = 1000;
    localparam int unsigned FILT_CYCLES = FILT_TIME_US * CLK_MHZ;
    localparam int unsigned LOW_PIN_CYCLES = LOW_PIN_TIME_US * CLK_MHZ;
    localparam int unsigned HOLD_CYCLES = HOLD_TIME_US * CLK_MHZ;
    localparam int unsigned MS_CYCLES = MS_TIME_US * CLK_MHZ;

    // ==========================================================
    // Over-voltage duration ranges in milliseconds
    // ==========================================================
    localparam logic [9:0] DUR_MS_10 = 10'h00a;
    localparam logic [9:0] DUR_MS_30 = 10'h01e;
    localparam logic [9:0] DUR_MS_100 = 10'h064;
    localparam logic [9:0] DUR_MS_300 = 10'h12c;
    localparam logic [9:0] DUR_MS_1000 = 10'h3e8;

    localparam logic [2:0] CODE_UNUSED = 3'h0;
    localparam logic [2:0] CODE_NONE = 3'h1;
    localparam logic [2:0] CODE_TO_10 = 3'h2;
    localparam logic [2:0] CODE_TO_30 = 3'h3;
    localparam logic [2:0] CODE_TO_100 = 3'h4;
    localparam logic [2:0] CODE_TO_300 = 3'h5;
    localparam logic [2:0] CODE_TO_1000 = 3'h6;
    localparam logic [2:0] CODE_OVER_1000 = 3'h7;

    // ==========================================================
    // Answer frame field positions (16-bit frames)
    // ==========================================================
    localparam int unsigned FRAME_W = 16;
    localparam int unsigned F8A_LOW_LATCHED = 1;
    localparam int unsigned F8A_HIGH_LATCHED = 2;
    localparam int unsigned F12B_LOW_LIVE = 0;
    localparam int unsigned F12B_HIGH_LIVE = 1;
    localparam int unsigned F12A_CODE_LSB = 9;
    localparam int unsigned F12A_CODE_MSB = 11;

endpackage

//--- hw/filter_if.sv
`timescale 1ns/100ps
// Raw comparator level in, filtered level out.
interface filter_if;
    logic raw;
    logic filt;
    modport owner (output raw, input filt);
    modport filter (input raw, output filt);
endinterface

//--- hw/level_filter.sv
`timescale 1ns/100ps
module level_filter #(
    parameter int unsigned LIMIT = 400000
) (
    input wire logic clk,
    input wire logic rst_n,
    filter_if.filter port
);
    // ==========================================================
    // Symmetric digital filter
    // ==========================================================
    logic [31:0] cnt_ff;
    logic filt_ff;

    assign port.filt = filt_ff;

    // Count only while raw differs from the filtered level; any return
    // before expiry restarts the count, so glitches never get through.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff <= 32'h0;
        end else if (port.raw == filt_ff) begin
            cnt_ff <= 32'h0;
        end else if (cnt_ff == 32'(LIMIT - 1)) begin
            cnt_ff <= 32'h0;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
        end
    end

    // The filtered level follows raw once the full time has passed.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            filt_ff <= 1'b0;
        end else if (port.raw != filt_ff && cnt_ff == 32'(LIMIT - 1)) begin
            filt_ff <= port.raw;
        end
    end

    AST_FILT_TIME: assert property (@(posedge clk) disable iff (!rst_n)
        filt_ff != $past(filt_ff) |-> $past(cnt_ff) == 32'(LIMIT - 1))
        else $error("filtered level changed before filter time");
endmodule

//--- testbench/rail_model.sv
`timescale 1ns/100ps
// ==========================================================
// Comparators and host strobes
// ==========================================================
// Stands in for the two rail comparators and the host's SPI side.
module rail_model (
    input wire logic clk,
    input wire logic want_low,
    input wire logic want_high,
    input wire logic rd_req,
    input wire logic clr_req,
    output logic low_cmp = 1'b0,
    output logic high_cmp = 1'b0,
    output logic code_read = 1'b0,
    output logic diag_clear = 1'b0
);
    // Comparators follow the rail one clock late; no filtering is done
    // here, so any glitch the bench asks for reaches the design whole.
    always @(posedge clk) begin
        low_cmp <= want_low;
        high_cmp <= want_high;
    end
    // Host read and clear strobes last one cycle per request cycle.
    always @(posedge clk) begin
        code_read <= rd_req;
        diag_clear <= clr_req;
    end
endmodule

//--- testbench/logic_supply_monitor_tb.sv
`timescale 1ns/100ps
module logic_supply_monitor_tb;
    import supply_mon_pkg::*;
    // Short counts keep the run brief; every expectation scales from them.
    localparam int unsigned FILT = 20;
    localparam int unsigned LPIN = 200;
    localparam int unsigned HOLD = 30;
    localparam int unsigned MSC = 5;
    logic clk, rst_n, want_low, want_high, rd_req, clr_req;
    logic low_cmp, high_cmp, code_read, diag_clear;
    logic bridge_disable, fault_pin_level, fault_pin_oe, high_to_global_fail;
    logic [FRAME_W-1:0] frame_8a, frame_12a, frame_12b;
    int fails = 0;
    int n_tests = 0;

    // ==========================================================
    // Clock, partner and design
    // ==========================================================
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    rail_model rail_model_inst (.clk(clk), .want_low(want_low),
        .want_high(want_high), .rd_req(rd_req), .clr_req(clr_req),
        .low_cmp(low_cmp), .high_cmp(high_cmp), .code_read(code_read),
        .diag_clear(diag_clear));
    logic_supply_monitor #(.FILT_LIMIT(FILT), .LOW_PIN_LIMIT(LPIN),
        .HOLD_LIMIT(HOLD), .MS_LIMIT(MSC)) logic_supply_monitor_inst (
        .clk(clk), .rst_n(rst_n), .low_cmp(low_cmp), .high_cmp(high_cmp),
        .code_read(code_read), .diag_clear(diag_clear),
        .bridge_disable(bridge_disable), .fault_pin_level(fault_pin_level),
        .fault_pin_oe(fault_pin_oe), .high_to_global_fail(high_to_global_fail),
        .frame_8a(frame_8a), .frame_12a(frame_12a), .frame_12b(frame_12b));

    // ==========================================================
    // Shared helpers
    // ==========================================================
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Outputs are sampled on falling edges, well clear of the update.
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Bounded wait for the bridge state; t returns the cycles spent.
    task automatic wait_bd(input logic val, input int lim, output int t);
        t = 0;
        while (bridge_disable !== val && t < lim) begin
            @(negedge clk);
            t++;
        end
    endtask
    task automatic host(input logic rd, input logic clr);
        @(posedge clk);
        rd_req <= rd;
        clr_req <= clr;
        @(posedge clk);
        rd_req <= 1'b0;
        clr_req <= 1'b0;
        idle(3);
    endtask
    task automatic set_high(input logic v);
        @(posedge clk);
        want_high <= v;
        @(negedge clk);
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    // Two pulses, each shorter than the filter, with a gap between them.
    task automatic glitch_test();
        int seen;
        seen = 0;
        set_high(1'b1);
        idle(FILT - 4);
        set_high(1'b0);
        set_high(1'b1);
        idle(FILT - 4);
        set_high(1'b0);
        repeat (3 * FILT) begin
            @(negedge clk);
            if (bridge_disable !== 1'b0 || fault_pin_oe !== 1'b0) seen++;
        end
        check(16'(seen), 16'h0);
        check(frame_8a | frame_12b, 16'h0);
        check(16'(frame_12a[11:9]), 16'h1);
    endtask
    // Long event walks every duration code, then a read while live.
    task automatic ov_long();
        int t;
        int ms[6] = '{5, 20, 60, 200, 600, 1100};
        set_high(1'b1);
        wait_bd(1'b1, FILT + 10, t);
        check(16'(t >= FILT), 16'h1);
        check(16'(bridge_disable), 16'h1);
        idle(2);
        check(16'(fault_pin_oe), 16'h1);
        check(16'(fault_pin_level), 16'h0);
        check(16'(high_to_global_fail), 16'h1);
        check(frame_12b, 16'h2);
        check(frame_8a, 16'h4);
        check(frame_12a, 16'h0400);
        t = 3;
        for (int i = 0; i < 6; i++) begin
            idle(ms[i] * MSC - t);
            t = ms[i] * MSC;
            check(16'(frame_12a[11:9]), 16'(i + 2));
        end
        host(1'b0, 1'b1);
        check(frame_8a, 16'h4);
        host(1'b1, 1'b0);
        check(16'(frame_12a[11:9]), 16'h2);
        set_high(1'b0);
        wait_bd(1'b0, FILT + 10, t);
        check(16'(t >= FILT), 16'h1);
        check(16'(bridge_disable), 16'h0);
        idle(2);
        check(16'(high_to_global_fail), 16'h0);
        check(frame_12b, 16'h0);
        check(frame_8a, 16'h4);
        idle(15 * MSC);
        check(16'(frame_12a[11:9]), 16'h2);
    endtask
    // Medium event, then a shorter one that must not lower the code.
    task automatic ov_replace();
        int t;
        int n;
        host(1'b1, 1'b0);
        check(frame_12a, 16'h0200);
        set_high(1'b1);
        wait_bd(1'b1, FILT + 10, t);
        idle(15 * MSC);
        set_high(1'b0);
        wait_bd(1'b0, FILT + 10, t);
        idle(HOLD);
        check(16'(frame_12a[11:9]), 16'h3);
        set_high(1'b1);
        wait_bd(1'b1, FILT + 10, t);
        set_high(1'b0);
        n = 0;
        while (fault_pin_oe === 1'b1 && n < FILT + 2 * HOLD) begin
            @(negedge clk);
            n++;
        end
        check(16'(n >= HOLD - 3), 16'h1);
        check(16'(bridge_disable), 16'h0);
        check(16'(fault_pin_oe), 16'h0);
        check(16'(frame_12a[11:9]), 16'h3);
        host(1'b1, 1'b1);
        check(frame_12a, 16'h0200);
        check(frame_8a, 16'h0);
    endtask
    // Under-voltage: short stage disables the bridge, long one the pin.
    task automatic uv_test();
        int t;
        @(posedge clk);
        want_low <= 1'b1;
        @(negedge clk);
        wait_bd(1'b1, FILT + 10, t);
        check(16'(t >= FILT), 16'h1);
        idle(2);
        check(frame_12b, 16'h1);
        check(frame_8a, 16'h2);
        check(16'(fault_pin_oe), 16'h0);
        t += 3;
        while (fault_pin_oe !== 1'b1 && t < LPIN + 10) begin
            @(negedge clk);
            t++;
        end
        check(16'(t >= LPIN), 16'h1);
        check(16'(fault_pin_oe), 16'h1);
        @(posedge clk);
        want_low <= 1'b0;
        @(negedge clk);
        wait_bd(1'b0, FILT + 10, t);
        check(16'(t >= FILT), 16'h1);
        idle(HOLD);
        check(16'(fault_pin_oe), 16'h0);
        check(frame_12b, 16'h0);
        check(frame_8a, 16'h2);
        host(1'b0, 1'b1);
        check(frame_8a, 16'h0);
    endtask

    // ==========================================================
    // Verdict, watchdog and main sequence
    // ==========================================================
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // The longest scenario needs about 6000 cycles; this leaves ample room.
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        give_verdict();
    end
    initial begin
        rst_n = 1'b0;
        want_low = 1'b0;
        want_high = 1'b0;
        rd_req = 1'b0;
        clr_req = 1'b0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        check(16'(bridge_disable), 16'h1);
        @(posedge clk);
        rst_n <= 1'b1;
        idle(5);
        check(frame_8a | frame_12b, 16'h0);
        check(frame_12a, 16'h0200);
        check(16'(fault_pin_oe), 16'h0);
        check(16'(bridge_disable), 16'h0);
        glitch_test();
        ov_long();
        ov_replace();
        uv_test();
        give_verdict();
    end
endmodule
